// ==== hw/servo_door_sequencer.sv ====
// two-channel timed servo trajectory sequencer
// assumes control values and config strobes synchronous to clk
`timescale 1ns/10ps
module servo_door_sequencer #(
  parameter int TICK_CYC = seq_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control inputs
  input wire logic [seq_pkg::NCH-1:0][seq_pkg::CTL_W-1:0] ctl_val,
  input wire seq_pkg::ctl_cfg_t [seq_pkg::NCH-1:0] ctl_cfg,
  // configuration
  input wire seq_pkg::pt_wr_t pt_wr,
  input wire seq_pkg::sel_t cnt_wr,
  input wire logic srv_cnt_wr,
  input wire logic srv_cnt_ch,
  input wire logic [seq_pkg::SRV_W-1:0] srv_cnt_val,
  input wire seq_pkg::sel_t prv_go,
  // servo side and status
  output logic [seq_pkg::NCH-1:0][seq_pkg::NSRV-1:0][seq_pkg::POS_W-1:0] srv_pos,
  output logic [seq_pkg::NCH-1:0][seq_pkg::NSRV-1:0] srv_owned,
  output logic [seq_pkg::NCH-1:0] seq_running,
  output logic [seq_pkg::NCH-1:0] seq_dir,
  output logic preview_on,
  output logic cfg_err
);
  import seq_pkg::*;

  seq_state_t st_reg;
  seq_state_t st_next;
  logic tick;
  logic [NCH-1:0][1:0] cls_c;
  logic [NCH-1:0][1:0][TIME_W-1:0] tlen;

  // ==========================================
  // interpolation
  function automatic logic [POS_W-1:0] interp(input pos_row_t p, input tim_row_t tm,
                                              input logic [PT_W-1:0] n, input logic [TIME_W-1:0] t);
    logic signed [POS_W:0] dp;
    logic [TIME_W-1:0] seg;
    logic [TIME_W-1:0] el;
    logic signed [MUL_W-1:0] prod;
    logic [POS_W-1:0] r;
    r = p[n - 3'h1];
    // lowest matching segment wins, so scan downward
    for (int i = NPT - 2; i >= 0; i--) begin
      if (PT_W'(i + 1) < n && t < tm[i+1]) begin
        seg = tm[i+1] - tm[i];
        el = t - tm[i];
        dp = {p[i+1][POS_W-1], p[i+1]} - {p[i][POS_W-1], p[i]};
        prod = MUL_W'(dp) * MUL_W'($signed({1'b0, el}));
        if (seg == '0) begin
          r = p[i+1];
        end else begin
          r = POS_W'(MUL_W'($signed(p[i])) + prod / MUL_W'($signed({1'b0, seg})));
        end
      end
    end
    return r;
  endfunction : interp

  // ==========================================
  // next state
  always_comb begin
    logic signed [CTL_W-1:0] v;
    logic [TIME_W-1:0] te;
    logic adv;
    logic want;
    logic opp;
    logic [PT_W-1:0] last;
    st_next = st_reg;
    st_next.cfg_err = 1'b0;
    v = '0;
    te = '0;
    adv = 1'b0;
    want = 1'b0;
    opp = 1'b0;
    last = '0;
    tick = st_reg.tick_cnt == TICK_W'(TICK_CYC - 1);
    st_next.tick_cnt = tick ? '0 : st_reg.tick_cnt + 1'b1;
    // run length per direction is the latest last point over the assigned servos
    for (int c = 0; c < NCH; c++) begin
      for (int d = 0; d < 2; d++) begin
        tlen[c][d] = '0;
        for (int s = 0; s < NSRV; s++) begin
          last = st_reg.npt[c][s][d] - 3'h1;
          if (SRV_W'(s) < st_reg.nsrv[c] && st_reg.tim[c][s][d][last] > tlen[c][d]) begin
            tlen[c][d] = st_reg.tim[c][s][d][last];
          end
        end
      end
    end
    for (int c = 0; c < NCH; c++) begin
      v = ctl_cfg[c].invert ? -$signed(ctl_val[c]) : $signed(ctl_val[c]);
      if (v >= ctl_cfg[c].fwd_thr) begin
        cls_c[c] = CL_FWD;
      end else if (v <= ctl_cfg[c].rev_thr) begin
        cls_c[c] = CL_REV;
      end else begin
        cls_c[c] = CL_PAUSE;
      end
      st_next.cls[c] = cls_c[c];
      te = tlen[c][st_reg.dir[c]];
      // no time advance in pause band
      adv = tick && st_reg.st[c] == ST_RUN && cls_c[c] != CL_PAUSE;
      want = cls_c[c] == CL_REV;
      if (ctl_cfg[c].loop_mode) begin
        st_next.dir[c] = 1'b0;
        if (st_reg.st[c] != ST_RUN && cls_c[c] == CL_FWD) begin
          st_next.st[c] = ST_RUN;
          st_next.t[c] = '0;
        end else if (adv) begin
          // repeat while active, else finish this pass
          if (st_reg.t[c] + 1'b1 >= te) begin
            if (cls_c[c] == CL_FWD) begin
              st_next.t[c] = '0;
            end else begin
              st_next.t[c] = te;
              st_next.st[c] = ST_DONE;
            end
          end else begin
            st_next.t[c] = st_reg.t[c] + 1'b1;
          end
        end
      end else if (cls_c[c] != CL_PAUSE) begin
        if (st_reg.st[c] == ST_RUN && want != st_reg.dir[c]) begin
          // mirror elapsed time onto the other trajectory
          st_next.dir[c] = want;
          st_next.t[c] = tlen[c][want] > st_reg.t[c] ? tlen[c][want] - st_reg.t[c] : '0;
        end else if (st_reg.st[c] == ST_IDLE || (st_reg.st[c] == ST_DONE && want != st_reg.dir[c])) begin
          st_next.st[c] = ST_RUN;
          st_next.dir[c] = want;
          st_next.t[c] = '0;
        end else if (adv) begin
          // single pass stops on final points
          if (st_reg.t[c] + 1'b1 >= te) begin
            st_next.t[c] = te;
            st_next.st[c] = ST_DONE;
          end else begin
            st_next.t[c] = st_reg.t[c] + 1'b1;
          end
        end
      end
    end
    // ==========================================
    // outputs per servo
    for (int c = 0; c < NCH; c++) begin
      for (int s = 0; s < NSRV; s++) begin
        // assigned servos driven by the sequencer only
        st_next.owned[c][s] = SRV_W'(s) < st_reg.nsrv[c];
        if (!st_next.owned[c][s]) begin
          st_next.out[c][s] = '0;
        end else if (st_reg.prv_on && st_reg.prv.ch == 1'(c) && st_reg.prv.srv == SRV_W'(s)) begin
          st_next.out[c][s] = st_reg.prv_pos;
        end else begin
          st_next.out[c][s] = interp(st_reg.pos[c][s][st_reg.dir[c]], st_reg.tim[c][s][st_reg.dir[c]],
                                     st_reg.npt[c][s][st_reg.dir[c]], st_reg.t[c]);
        end
      end
    end
    // ==========================================
    // preview slew
    // control operation cancels preview
    if (st_reg.prv_on && cls_c[st_reg.prv.ch] != st_reg.cls[st_reg.prv.ch]) begin
      st_next.prv_on = 1'b0;
    end
    if (prv_go.wr) begin
      st_next.prv_on = 1'b1;
      st_next.prv = prv_go;
      st_next.prv_pos = st_reg.out[prv_go.ch][prv_go.srv];
    end else if (st_reg.prv_on && tick) begin
      v = '0;
      if ($signed(st_reg.prv_pos) < $signed(st_reg.pos[st_reg.prv.ch][st_reg.prv.srv][st_reg.prv.dir][st_reg.prv.pt])) begin
        st_next.prv_pos = st_reg.prv_pos + PRV_STEP;
      end else if (st_reg.prv_pos != st_reg.pos[st_reg.prv.ch][st_reg.prv.srv][st_reg.prv.dir][st_reg.prv.pt]) begin
        st_next.prv_pos = st_reg.prv_pos - PRV_STEP;
      end
    end
    // ==========================================
    // configuration writes
    if (pt_wr.wr) begin
      opp = ~pt_wr.dir;
      last = st_reg.npt[pt_wr.ch][pt_wr.srv][pt_wr.dir] - 3'h1;
      if (pt_wr.pt < PT_W'(NPT) && pt_wr.srv < MAX_SRV) begin
        st_next.pos[pt_wr.ch][pt_wr.srv][pt_wr.dir][pt_wr.pt] = pt_wr.pos;
        if (pt_wr.pt != '0) begin
          st_next.tim[pt_wr.ch][pt_wr.srv][pt_wr.dir][pt_wr.pt] = pt_wr.tm;
        end
        // keep ends of both directions consistent
        if (pt_wr.pt == '0) begin
          st_next.pos[pt_wr.ch][pt_wr.srv][opp][st_reg.npt[pt_wr.ch][pt_wr.srv][opp] - 3'h1] = pt_wr.pos;
        end
        if (pt_wr.pt == last) begin
          st_next.pos[pt_wr.ch][pt_wr.srv][opp][0] = pt_wr.pos;
        end
      end else begin
        st_next.cfg_err = 1'b1;
      end
    end
    if (cnt_wr.wr) begin
      if (cnt_wr.pt >= MIN_NPT && cnt_wr.srv < MAX_SRV) begin
        st_next.npt[cnt_wr.ch][cnt_wr.srv][cnt_wr.dir] = cnt_wr.pt;
      end else begin
        st_next.cfg_err = 1'b1;
      end
    end
    if (srv_cnt_wr) begin
      if (srv_cnt_val <= MAX_SRV) begin
        st_next.nsrv[srv_cnt_ch] = srv_cnt_val;
      end else begin
        st_next.cfg_err = 1'b1;
      end
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      for (int c = 0; c < NCH; c++) begin
        st_reg.st[c] <= ST_IDLE;
        for (int s = 0; s < NSRV; s++) begin
          // default two points, 6.0 s, -20 % to +20 %
          st_reg.npt[c][s] <= {DEF_NPT, DEF_NPT};
          st_reg.tim[c][s][0][1] <= DEF_TIME;
          st_reg.tim[c][s][1][1] <= DEF_TIME;
          st_reg.pos[c][s][0][0] <= -DEF_POS;
          st_reg.pos[c][s][0][1] <= DEF_POS;
          st_reg.pos[c][s][1][0] <= DEF_POS;
          st_reg.pos[c][s][1][1] <= -DEF_POS;
        end
      end
    end else begin
      st_reg <= st_next;
    end
  end

  assign srv_pos = st_reg.out;
  assign srv_owned = st_reg.owned;
  assign seq_dir = st_reg.dir;
  assign preview_on = st_reg.prv_on;
  assign cfg_err = st_reg.cfg_err;
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      seq_running[c] = st_reg.st[c] == ST_RUN;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  pause_hold_a: assert property (st_reg.st[0] == ST_RUN && cls_c[0] == CL_PAUSE |=> $stable(st_reg.t[0]))
    else $error("time moved during pause");
  reverse_a: assert property (!ctl_cfg[0].loop_mode && st_reg.st[0] == ST_RUN && cls_c[0] == CL_REV
    && !st_reg.dir[0] |=> st_reg.dir[0] && st_reg.st[0] == ST_RUN) else $error("no reversal mid-run");
  fwd_dir_a: assert property (!ctl_cfg[0].loop_mode && cls_c[0] == CL_FWD |=> !st_reg.dir[0])
    else $error("forward band not forward");
  single_stop_a: assert property (!ctl_cfg[0].loop_mode && st_reg.st[0] == ST_RUN && tick && cls_c[0] == CL_FWD
    && !st_reg.dir[0] && st_reg.t[0] + 1'b1 >= tlen[0][0] |=> st_reg.st[0] == ST_DONE
    && st_reg.t[0] == $past(tlen[0][0])) else $error("single run did not stop at end");
  loop_wrap_a: assert property (ctl_cfg[0].loop_mode && st_reg.st[0] == ST_RUN && tick && cls_c[0] == CL_FWD
    && st_reg.t[0] + 1'b1 >= tlen[0][st_reg.dir[0]] |=> st_reg.t[0] == '0 && st_reg.st[0] == ST_RUN)
    else $error("loop did not wrap");
  loop_finish_a: assert property (ctl_cfg[0].loop_mode && st_reg.st[0] == ST_RUN && tick && cls_c[0] == CL_REV
    && st_reg.t[0] + 1'b1 >= tlen[0][st_reg.dir[0]] |=> st_reg.st[0] == ST_DONE) else $error("loop did not stop");
  srv_limit_a: assert property (st_reg.nsrv[0] <= MAX_SRV && st_reg.nsrv[1] <= MAX_SRV)
    else $error("servo count above six");
  t0_fixed_a: assert property (st_reg.tim[0][0][0][0] == '0 && st_reg.tim[1][5][1][0] == '0)
    else $error("first point time not zero");
  end_sync_a: assert property (pt_wr.wr && !pt_wr.ch && pt_wr.srv == '0 && !pt_wr.dir && pt_wr.pt == '0
    && !cnt_wr.wr |=> st_reg.pos[0][0][1][st_reg.npt[0][0][1] - 3'h1] == $past(pt_wr.pos))
    else $error("opposite end not updated");
  owned_a: assert property (1'b1 |=> st_reg.owned[0][0] == ($past(st_reg.nsrv[0]) != '0))
    else $error("ownership mask wrong");

  single_done_c: cover property (!ctl_cfg[0].loop_mode && st_reg.st[0] == ST_RUN ##1 st_reg.st[0] == ST_DONE);
  reverse_c: cover property (st_reg.st[0] == ST_RUN && !st_reg.dir[0] ##1 st_reg.st[0] == ST_RUN && st_reg.dir[0]);
  loop_wrap_c: cover property (ctl_cfg[1].loop_mode && st_reg.t[1] != '0 ##1 st_reg.t[1] == '0);
  preview_cancel_c: cover property (st_reg.prv_on ##1 !st_reg.prv_on);
endmodule : servo_door_sequencer

// ==== hw/seq_pkg.sv ====
// constants, carrier types and the state record of the door sequencer
// assumes a single 40 MHz clock; positions in 0.1 % steps, times in ms
package seq_pkg;
  // ==========================================
  // sizes
  localparam int NCH = 2;
  localparam int NSRV = 6;
  localparam int NPT = 7;
  localparam int POS_W = 12;
  localparam int TIME_W = 16;
  localparam int CTL_W = 12;
  localparam int SRV_W = 3;
  localparam int PT_W = 3;
  localparam int TICK_W = 20;
  localparam int MUL_W = POS_W + TIME_W + 2;
  // ==========================================
  // timing and defaults
  localparam int CLK_NS = 25;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam real DEF_RUN_S = 6.0;
  localparam int DEF_RUN_MS = int'(DEF_RUN_S * 1000.0);
  localparam int DEF_PCT = 20;
  localparam int POS_SCALE = 10;
  localparam logic [POS_W-1:0] DEF_POS = POS_W'(DEF_PCT * POS_SCALE);
  localparam logic [TIME_W-1:0] DEF_TIME = TIME_W'(DEF_RUN_MS);
  localparam logic [PT_W-1:0] DEF_NPT = 3'h2;
  localparam logic [PT_W-1:0] MIN_NPT = 3'h2;
  localparam logic [SRV_W-1:0] MAX_SRV = 3'h6;
  localparam logic [POS_W-1:0] PRV_STEP = 12'h001;
  // ==========================================
  // control classes and run states
  localparam logic [1:0] CL_PAUSE = 2'h0;
  localparam logic [1:0] CL_FWD = 2'h1;
  localparam logic [1:0] CL_REV = 2'h2;
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_RUN = 3'b010, ST_DONE = 3'b100} run_st_t;
  // ==========================================
  // carriers
  typedef struct packed {
    logic signed [CTL_W-1:0] fwd_thr;
    logic signed [CTL_W-1:0] rev_thr;
    logic invert;
    logic loop_mode;
  } ctl_cfg_t;
  typedef struct packed {
    logic wr;
    logic ch;
    logic [SRV_W-1:0] srv;
    logic dir;
    logic [PT_W-1:0] pt;
    logic [TIME_W-1:0] tm;
    logic [POS_W-1:0] pos;
  } pt_wr_t;
  typedef struct packed {
    logic wr;
    logic ch;
    logic [SRV_W-1:0] srv;
    logic dir;
    logic [PT_W-1:0] pt;
  } sel_t;
  typedef logic [NPT-1:0][POS_W-1:0] pos_row_t;
  typedef logic [NPT-1:0][TIME_W-1:0] tim_row_t;
  typedef struct packed {
    pos_row_t [NCH-1:0][NSRV-1:0][1:0] pos;
    tim_row_t [NCH-1:0][NSRV-1:0][1:0] tim;
    logic [NCH-1:0][NSRV-1:0][1:0][PT_W-1:0] npt;
    logic [NCH-1:0][SRV_W-1:0] nsrv;
    logic [TICK_W-1:0] tick_cnt;
    logic [NCH-1:0][TIME_W-1:0] t;
    run_st_t [NCH-1:0] st;
    logic [NCH-1:0] dir;
    logic [NCH-1:0][1:0] cls;
    logic prv_on;
    sel_t prv;
    logic [POS_W-1:0] prv_pos;
    logic [NCH-1:0][NSRV-1:0][POS_W-1:0] out;
    logic [NCH-1:0][NSRV-1:0] owned;
    logic cfg_err;
  } seq_state_t;
endpackage : seq_pkg

// ==== verification/pilot_switch_model.sv ====
// pilot side: a three-position switch per channel giving control values
// assumes thresholds stay inside +/-1000 unless a scenario moves them
`timescale 1ns/10ps
module pilot_switch_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // switch positions, coded as the control classes
  input wire logic [seq_pkg::NCH-1:0][1:0] sw_pos,
  // control values to the sequencer
  output logic [seq_pkg::NCH-1:0][seq_pkg::CTL_W-1:0] ctl_val
);
  import seq_pkg::*;
  // ==========================================
  // switch levels, one clock of travel like a real input path
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_val <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        ctl_val[i] <= (sw_pos[i] == CL_FWD) ? 12'h3e8 : (sw_pos[i] == CL_REV) ? 12'hc18 : 12'h000;
      end
    end
  end
endmodule : pilot_switch_model

// ==== verification/servo_door_sequencer_tb.sv ====
// self-checking bench for the door sequencer
// assumes the pilot switch model feeds the control values
`timescale 1ns/10ps
module servo_door_sequencer_tb;
  import seq_pkg::*;
  localparam int TK = 4;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [NCH-1:0][1:0] sw = '0;
  logic [NCH-1:0][CTL_W-1:0] ctl_val;
  ctl_cfg_t [NCH-1:0] ctl_cfg = {2{ctl_cfg_t'{12'h1f4, 12'he0c, 1'b0, 1'b0}}};
  pt_wr_t pt_wr = '0;
  sel_t cnt_wr = '0;
  sel_t prv_go = '0;
  logic srv_cnt_wr = 1'b0;
  logic srv_cnt_ch = 1'b0;
  logic [SRV_W-1:0] srv_cnt_val = '0;
  logic [NCH-1:0][NSRV-1:0][POS_W-1:0] srv_pos;
  logic [NCH-1:0][NSRV-1:0] srv_owned;
  logic [NCH-1:0] seq_running;
  logic [NCH-1:0] seq_dir;
  logic preview_on;
  logic cfg_err;
  logic signed [POS_W-1:0] p0;
  logic signed [POS_W-1:0] p;
  int fails = 0;
  int tests_run = 0;
  assign p0 = srv_pos[0][0];
  initial forever #12.5 clk = ~clk;
  pilot_switch_model pilot_switch_model_inst (.clk(clk), .arst_n(arst_n), .sw_pos(sw), .ctl_val(ctl_val));
  servo_door_sequencer #(.TICK_CYC(TK)) servo_door_sequencer_inst (
    .clk(clk), .arst_n(arst_n), .ctl_val(ctl_val), .ctl_cfg(ctl_cfg), .pt_wr(pt_wr), .cnt_wr(cnt_wr),
    .srv_cnt_wr(srv_cnt_wr), .srv_cnt_ch(srv_cnt_ch), .srv_cnt_val(srv_cnt_val), .prv_go(prv_go),
    .srv_pos(srv_pos), .srv_owned(srv_owned), .seq_running(seq_running), .seq_dir(seq_dir),
    .preview_on(preview_on), .cfg_err(cfg_err));
  // ==========================================
  // shared tasks
  task automatic chk(input string n, input logic [POS_W-1:0] e, input logic [POS_W-1:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (fails == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // bounded wait on a channel's run flag
  task automatic wait_run(input int ch, input logic v, input int n);
    int k;
    k = 0;
    while (seq_running[ch] !== v && k < n) begin
      cyc(1);
      k++;
    end
    if (seq_running[ch] !== v) begin
      fails++;
      $display("unexpected seq_running: expected %b seen %b", v, seq_running[ch]);
      tally_and_finish();
    end
  endtask : wait_run
  task automatic set_sw(input int ch, input logic [1:0] v);
    @(posedge clk);
    sw[ch] <= v;
  endtask : set_sw
  task automatic err_chk(input logic e);
    logic seen;
    seen = 1'b0;
    // error pulse stands one cycle right after the taking edge
    #1;
    repeat (3) begin
      seen = seen | cfg_err;
      cyc(1);
    end
    chk("cfg_err", e, seen);
  endtask : err_chk
  task automatic wr_pt(input logic [2:0] s, input logic d, input logic [2:0] t, input logic [15:0] tm,
                       input logic [11:0] ps, input logic e);
    @(posedge clk);
    pt_wr <= '{1'b1, 1'b0, s, d, t, tm, ps};
    @(posedge clk);
    pt_wr.wr <= 1'b0;
    err_chk(e);
  endtask : wr_pt
  task automatic wr_cnt(input logic ch, input logic [2:0] v, input logic e);
    @(posedge clk);
    srv_cnt_wr <= 1'b1;
    srv_cnt_ch <= ch;
    srv_cnt_val <= v;
    @(posedge clk);
    srv_cnt_wr <= 1'b0;
    err_chk(e);
  endtask : wr_cnt
  // single run on channel 0 to its end, then the end position
  task automatic run_end(input logic [11:0] e);
    wait_run(0, 1'b0, 30 * TK);
    cyc(2);
    chk("end pos", e, p0);
  endtask : run_end
  // ==========================================
  // scenarios
  task automatic sc_refuse();
    wr_cnt(1'b0, 3'h7, 1'b1);
    wr_cnt(1'b0, 3'h6, 1'b0);
    chk("owned", 12'h03f, srv_owned[0]);
    wr_cnt(1'b0, 3'h1, 1'b0);
    chk("owned", 12'h001, srv_owned[0]);
    wr_pt(3'h0, 1'b0, 3'h7, 16'h0, 12'h0, 1'b1);
    wr_pt(3'h6, 1'b0, 3'h1, 16'h0, 12'h0, 1'b1);
    @(posedge clk);
    cnt_wr <= '{1'b1, 1'b0, 3'h0, 1'b0, 3'h1};
    @(posedge clk);
    cnt_wr.wr <= 1'b0;
    err_chk(1'b1);
    wr_pt(3'h0, 1'b0, 3'h1, 16'h0014, 12'h0c8, 1'b0);
    wr_pt(3'h0, 1'b1, 3'h1, 16'h0014, 12'hf38, 1'b0);
  endtask : sc_refuse
  task automatic sc_pause();
    set_sw(0, CL_FWD);
    wait_run(0, 1'b1, 8);
    cyc(10 * TK);
    set_sw(0, CL_PAUSE);
    cyc(4);
    p = p0;
    cyc(20 * TK);
    chk("paused pos", p, p0);
    chk("mid pos", 1'b1, p > -200 && p < 200);
    set_sw(0, CL_FWD);
    cyc(4);
    run_end(12'h0c8);
  endtask : sc_pause
  task automatic sc_reverse();
    set_sw(0, CL_REV);
    wait_run(0, 1'b1, 8);
    chk("dir", 1'b1, seq_dir[0]);
    cyc(8 * TK);
    p = p0;
    set_sw(0, CL_FWD);
    cyc(4);
    chk("dir", 1'b0, seq_dir[0]);
    chk("no jump", 1'b1, p0 - p <= 40 && p - p0 <= 40);
    chk("running", 1'b1, seq_running[0]);
    run_end(12'h0c8);
  endtask : sc_reverse
  task automatic sc_loop();
    int k;
    k = 0;
    wr_pt(3'h0, 1'b0, 3'h0, 16'h0005, 12'hf6a, 1'b0);
    set_sw(0, CL_REV);
    wait_run(0, 1'b1, 8);
    run_end(12'hf6a);
    @(posedge clk);
    ctl_cfg[0].loop_mode <= 1'b1;
    set_sw(0, CL_FWD);
    wait_run(0, 1'b1, 8);
    cyc(1);
    chk("start pos", 12'hf6a, p0);
    repeat (60 * TK) begin
      cyc(1);
      if (seq_running[0] !== 1'b1) k++;
    end
    chk("loop gaps", 12'h0, 12'(k));
    set_sw(0, CL_REV);
    run_end(12'h0c8);
  endtask : sc_loop
  task automatic sc_sense();
    set_sw(0, CL_PAUSE);
    @(posedge clk);
    ctl_cfg[0] <= '{12'h1f4, 12'he0c, 1'b1, 1'b0};
    set_sw(0, CL_FWD);
    wait_run(0, 1'b1, 8);
    chk("inverted dir", 1'b1, seq_dir[0]);
    run_end(12'hf6a);
    set_sw(0, CL_PAUSE);
    @(posedge clk);
    ctl_cfg[0] <= '{12'h3e9, 12'he0c, 1'b0, 1'b0};
    set_sw(0, CL_FWD);
    cyc(8);
    chk("below thr", 1'b0, seq_running[0]);
    set_sw(0, CL_PAUSE);
    @(posedge clk);
    ctl_cfg[0].fwd_thr <= 12'h1f4;
  endtask : sc_sense
  task automatic sc_preview();
    @(posedge clk);
    prv_go <= '{1'b1, 1'b0, 3'h0, 1'b0, 3'h1};
    @(posedge clk);
    prv_go.wr <= 1'b0;
    cyc(3);
    chk("preview", 1'b1, preview_on);
    cyc(10 * TK);
    chk("slow slew", 1'b1, p0 > -150 && p0 < -130);
    set_sw(0, CL_FWD);
    cyc(4);
    chk("preview", 1'b0, preview_on);
    wait_run(0, 1'b1, 8);
    run_end(12'h0c8);
  endtask : sc_preview
  // three-point forward trajectory whose first segment holds still
  task automatic sc_hold();
    @(posedge clk);
    cnt_wr <= '{1'b1, 1'b0, 3'h0, 1'b0, 3'h3};
    @(posedge clk);
    cnt_wr.wr <= 1'b0;
    err_chk(1'b0);
    wr_pt(3'h0, 1'b0, 3'h1, 16'h000a, 12'hf6a, 1'b0);
    wr_pt(3'h0, 1'b0, 3'h2, 16'h0014, 12'h0c8, 1'b0);
    set_sw(0, CL_REV);
    wait_run(0, 1'b1, 8);
    run_end(12'hf6a);
    set_sw(0, CL_FWD);
    wait_run(0, 1'b1, 8);
    cyc(5 * TK);
    chk("hold pos", 12'hf6a, p0);
    run_end(12'h0c8);
  endtask : sc_hold
  task automatic sc_defaults();
    wr_cnt(1'b1, 3'h1, 1'b0);
    set_sw(1, CL_FWD);
    wait_run(1, 1'b1, 8);
    cyc(1);
    chk("ch1 start", 12'hf38, srv_pos[1][0]);
    chk("ch0 idle", 1'b0, seq_running[0]);
    cyc(5900 * TK);
    chk("ch1 running", 1'b1, seq_running[1]);
    wait_run(1, 1'b0, 200 * TK);
    cyc(2);
    chk("ch1 end", 12'h0c8, srv_pos[1][0]);
  endtask : sc_defaults
  // ==========================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    cyc(2);
    chk("reset owned", 12'h0, srv_owned[0]);
    sc_refuse();
    sc_pause();
    sc_reverse();
    sc_loop();
    sc_sense();
    sc_preview();
    sc_hold();
    sc_defaults();
    tally_and_finish();
  end
endmodule : servo_door_sequencer_tb
